// File: core/ars_params.svh
// ars_params.svh: offsets, field positions, reset values and codes of the slice.
// Assumes inclusion by bare name from the slice module and the testbench.
`ifndef ARS_PARAMS_SVH
`define ARS_PARAMS_SVH

// ----------------------------------------------------------------
// register map (byte addresses on the 8-bit AXI4-Lite address)
// ----------------------------------------------------------------
`define ARS_ADDR_W 8
`define ARS_OFF_CTRL 8'h00
`define ARS_OFF_STATUS 8'h04
`define ARS_OFF_WORD_BASE 8'h20
`define ARS_OFF_WORD_LAST 8'h3c

// ----------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------
`define ARS_CTRL_HOLD_BIT 0
`define ARS_CTRL_RESET 1'h0
`define ARS_ST_RESULT_LSB 0
`define ARS_ST_RIPPLE_BIT 4
`define ARS_ST_PROP_BIT 5
`define ARS_ST_GEN_BIT 6
`define ARS_ST_ZERO_BIT 7
`define ARS_ST_LINE_BIT 8
`define ARS_ST_CLK_BIT 9

// ----------------------------------------------------------------
// slice geometry and pin reset levels
// ----------------------------------------------------------------
`define ARS_WORDS 8
`define ARS_SYNC_W 15
`define ARS_SYNC_RESET 15'h7000

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define ARS_RESP_OKAY 2'h0
`define ARS_RESP_SLVERR 2'h2

`endif

// File: core/ars_pkg.sv
// ars_pkg: types shared by the slice logic.
// Assumes nothing of its surroundings.
package ars_pkg;

    // eight function codes; the two 00x codes are the carry-using arithmetic ones
    typedef enum logic [2:0] {
        ARS_OP_ADD = 3'b000,
        ARS_OP_ADD_ALT = 3'b001,
        ARS_OP_AND = 3'b010,
        ARS_OP_OR = 3'b011,
        ARS_OP_XOR = 3'b100,
        ARS_OP_LOAD = 3'b101,
        ARS_OP_CLEAR = 3'b110,
        ARS_OP_KEEP = 3'b111
    } ars_op_t;

    // register decode outcome
    typedef enum logic [1:0] {
        ARS_SEL_CTRL = 2'b00,
        ARS_SEL_STATUS = 2'b01,
        ARS_SEL_WORD = 2'b10,
        ARS_SEL_NONE = 2'b11
    } ars_sel_t;

endpackage : ars_pkg

// File: core/ars_slice.sv
// ars_slice: one 4-bit arithmetic register slice with an AXI4-Lite window.
// Assumes slice pins arrive asynchronously to mclk and are resynchronised here;
// the wired-OR zero line and the output bus are resolved by the surroundings.
// pins are sampled, so each slice clock phase must last several mclk periods.
// word store and output register power up unknown; software reads them as they are.
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "ars_params.svh"

module ars_slice import ars_pkg::*; (
    input wire logic mclk,
    input wire logic rstn,
    // slice pins
    input wire logic [3:0] data_in_n,
    input wire logic [2:0] word_sel,
    input wire logic [2:0] func_sel,
    input wire logic top_slice_select,
    input wire logic slice_clock,
    input wire logic run_strobe_n,
    input wire logic out_drive_en_n,
    output logic [3:0] result_out_n,
    output logic result_oe_n,
    output logic ripple_link_n,
    output logic prop_neg_n,
    output logic gen_ovf_n,
    input wire logic zero_line_in,
    output logic zero_line_out,
    output logic zero_line_oe_n,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [`ARS_SYNC_W-1:0] sync1;
    logic [`ARS_SYNC_W-1:0] sync2;
    wire [`ARS_SYNC_W-1:0] pins_raw = {zero_line_in, out_drive_en_n, run_strobe_n, slice_clock,
                            top_slice_select, func_sel, word_sel, data_in_n};

    // first stage feeds only the second; reset parks clock low, strobe and enable high
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync1 <= `ARS_SYNC_RESET;
            sync2 <= `ARS_SYNC_RESET;
        end else begin
            sync1 <= pins_raw;
            sync2 <= sync1;
        end
    end

    // named views of the resynchronised pins
    wire [3:0] operand_d = ~sync2[3:0];
    wire [2:0] sel_word = sync2[6:4];
    wire [2:0] sel_func = sync2[9:7];
    wire top_slice = sync2[10];
    wire clk_lvl = sync2[11];
    wire strobe_n = sync2[12];
    wire drive_en_n = sync2[13];
    wire line_lvl = sync2[14];

    // ----------------------------------------------------------------
    // software control
    // ----------------------------------------------------------------
    logic ctrl_hold;
    // hold forces the strobe inactive, so software can freeze the slice
    wire exec_n = strobe_n | ctrl_hold;

    // ----------------------------------------------------------------
    // word store, latches and output register
    // ----------------------------------------------------------------
    // storage, its read latch and the ALU result that feeds both stores
    logic [3:0] ram [0:`ARS_WORDS-1];
    logic [3:0] latch_q;
    logic [3:0] out_reg;
    logic clk_prev;
    wire [3:0] alu_res;

    // active-low AND of clock-low and strobe: the write-back window
    wire write_win = ~clk_lvl & ~exec_n;

    // the output register loads at most once per microcycle, on the synced clock rise while the strobe is active
    wire clk_rise = clk_lvl & ~clk_prev;
    wire load_out = clk_rise & ~exec_n;

    // edge memory for the resynchronised slice clock
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            clk_prev <= 1'b0;
        end else begin
            clk_prev <= clk_lvl;
        end
    end

    // latches follow the selected word while the clock is high, hold while low
    always_ff @(posedge mclk) begin
        if (clk_lvl) begin
            latch_q <= ram[sel_word];
        end
    end

    // no reset on storage: contents stay unknown until a microcycle writes them
    always_ff @(posedge mclk) begin
        if (write_win) begin
            ram[sel_word] <= alu_res;
        end
        if (load_out) begin
            out_reg <= alu_res;
        end
    end

    // ----------------------------------------------------------------
    // ALU
    // ----------------------------------------------------------------
    wire [3:0] op_a = latch_q;
    wire arith = (sel_func[2:1] == 2'b00);
    // the carry chain is active low: a low bit zero means carry in
    wire carry_in = ~sel_func[0];
    wire [4:0] sum5 = {1'b0, op_a} + {1'b0, operand_d} + {4'h0, carry_in};

    // group terms for a lookahead unit; the carry-in takes no part in them
    wire [3:0] gen_b = op_a & operand_d;
    wire [3:0] prop_b = op_a | operand_d;
    wire grp_prop = &prop_b;
    wire grp_gen = gen_b[3] | (prop_b[3] & gen_b[2]) | (prop_b[3] & prop_b[2] & gen_b[1])
                   | (prop_b[3] & prop_b[2] & prop_b[1] & gen_b[0]);

    // logic functions; arithmetic codes take the sum instead
    function automatic logic [3:0] ars_logic(input ars_op_t op, input logic [3:0] a,
                                             input logic [3:0] d);
        logic [3:0] r;
        r = a;
        unique case (op)
            ARS_OP_AND: r = a & d;
            ARS_OP_OR: r = a | d;
            ARS_OP_XOR: r = a ^ d;
            ARS_OP_LOAD: r = d;
            ARS_OP_CLEAR: r = 4'h0;
            ARS_OP_KEEP: r = a;
            ARS_OP_ADD, ARS_OP_ADD_ALT: r = a + d;
        endcase
        return r;
    endfunction : ars_logic

    // strobe does not gate the computation, only the stores
    wire [3:0] logic_res = ars_logic(ars_op_t'(sel_func), op_a, operand_d);
    assign alu_res = arith ? sum5[3:0] : logic_res;

    // overflow has meaning only for the add codes; logic codes never flag it
    wire ovf = arith & (op_a[3] == operand_d[3]) & (alu_res[3] != op_a[3]);
    wire res_zero = (alu_res == 4'h0);

    // ----------------------------------------------------------------
    // expansion outputs
    // ----------------------------------------------------------------
    wire next_ripple_n = arith ? ~sum5[4] : sel_func[0];
    // lower slices feed a lookahead unit, or pass bit zero through it on logic codes
    wire chain_prop_n = arith ? ~grp_prop : 1'b0;
    wire chain_gen_n = arith ? ~grp_gen : 1'b1;

    // the top slice swaps both for its sign and overflow status
    wire next_prop_n = top_slice ? ~alu_res[3] : chain_prop_n;
    wire next_gen_n = top_slice ? ~ovf : chain_gen_n;

    // retimed every mclk edge, independent of slice clock and strobe
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ripple_link_n <= 1'b1;
            prop_neg_n <= 1'b1;
            gen_ovf_n <= 1'b1;
            zero_line_oe_n <= 1'b1;
            zero_line_out <= 1'b0;
        end else begin
            ripple_link_n <= next_ripple_n;
            prop_neg_n <= next_prop_n;
            gen_ovf_n <= next_gen_n;
            zero_line_oe_n <= res_zero;
            zero_line_out <= 1'b0;
        end
    end

    // three-state result bus: value and enable registered together
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            result_out_n <= 4'hf;
            result_oe_n <= 1'b1;
        end else begin
            result_out_n <= ~out_reg;
            result_oe_n <= drive_en_n;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    function automatic ars_sel_t ars_decode(input logic [7:0] addr);
        ars_sel_t s;
        s = ARS_SEL_NONE;
        if (addr == `ARS_OFF_CTRL) begin
            s = ARS_SEL_CTRL;
        end else if (addr == `ARS_OFF_STATUS) begin
            s = ARS_SEL_STATUS;
        end else if (addr >= `ARS_OFF_WORD_BASE && addr <= `ARS_OFF_WORD_LAST
                     && addr[1:0] == 2'b00) begin
            s = ARS_SEL_WORD;
        end
        return s;
    endfunction : ars_decode

    // captured halves of a write; either channel may arrive first
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;

    // handshakes and address decode for both channels
    wire aw_fire = s_axi_awvalid & s_axi_awready;
    wire w_fire = s_axi_wvalid & s_axi_wready;
    wire do_write = aw_held & w_held;
    wire ars_sel_t wsel = ars_decode(awaddr_q);
    wire ars_sel_t rsel = ars_decode(s_axi_araddr);
    wire [2:0] rd_word = s_axi_araddr[4:2];

    // status fields placed by the shared bit positions; unused bits read zero
    wire [31:0] status_word = (32'(out_reg) << `ARS_ST_RESULT_LSB)
                              | (32'(ripple_link_n) << `ARS_ST_RIPPLE_BIT)
                              | (32'(prop_neg_n) << `ARS_ST_PROP_BIT)
                              | (32'(gen_ovf_n) << `ARS_ST_GEN_BIT)
                              | (32'(res_zero) << `ARS_ST_ZERO_BIT)
                              | (32'(line_lvl) << `ARS_ST_LINE_BIT)
                              | (32'(clk_lvl) << `ARS_ST_CLK_BIT);

    // unmapped reads return zero along with an error response
    wire [31:0] rd_mux = (rsel == ARS_SEL_CTRL) ? {31'h0, ctrl_hold} :
                         (rsel == ARS_SEL_STATUS) ? status_word :
                         (rsel == ARS_SEL_WORD) ? {28'h0, ram[rd_word]} : 32'h0;

    // write path: address and data taken in either order, answer after both
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb0_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ARS_RESP_OKAY;
            ctrl_hold <= `ARS_CTRL_RESET;
        end else begin
            if (aw_fire) begin
                aw_held <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_fire) begin
                w_held <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wsel == ARS_SEL_NONE) ? `ARS_RESP_SLVERR : `ARS_RESP_OKAY;
                if (wsel == ARS_SEL_CTRL && wstrb0_q) begin
                    ctrl_hold <= wdata_q[`ARS_CTRL_HOLD_BIT];
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read path: one cycle from address to data
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `ARS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= (rsel == ARS_SEL_NONE) ? `ARS_RESP_SLVERR : `ARS_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule : ars_slice

// File: tb/ars_slice_asserts.sv
// ars_slice_asserts: port-level checks on one arithmetic register slice.
// Assumes binding into ars_slice; pins pass two sync flops, then one output flop.
`timescale 1ns/1ps

module ars_slice_chk (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [2:0] func_sel,
    input wire logic top_slice_select,
    input wire logic run_strobe_n,
    input wire logic out_drive_en_n,
    input wire logic [3:0] result_out_n,
    input wire logic result_oe_n,
    input wire logic ripple_link_n,
    input wire logic prop_neg_n,
    input wire logic gen_ovf_n,
    input wire logic zero_line_out,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------
    // pin history
    // ------------------------------------------------------------
    // outputs trail the pins by three edges, so keep three samples
    logic [14:0] pin_hist;
    logic [2:0] up_cnt;
    logic [2:0] idle_cnt;
    wire [4:0] late = pin_hist[14:10];
    wire live = up_cnt[2];
    wire arith = (late[4:3] == 2'b00);

    // live waits out stale sync contents after reset release
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_hist <= 15'h0;
            up_cnt <= 3'h0;
            idle_cnt <= 3'h0;
        end else begin
            pin_hist <= {pin_hist[9:0], func_sel, top_slice_select, out_drive_en_n};
            up_cnt <= up_cnt + {2'h0, !live};
            idle_cnt <= run_strobe_n ? idle_cnt + {2'h0, idle_cnt != 3'h7} : 3'h0;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_oe_follow; live |-> result_oe_n == late[0]; endproperty
    a_oe_follow: assert property (p_oe_follow)
        else $error("bus enable did not follow its pin");
    property p_ripple_copy; live && !arith |-> ripple_link_n == late[2]; endproperty
    a_ripple_copy: assert property (p_ripple_copy)
        else $error("ripple output not a copy of function bit zero");
    property p_pass; live && !arith && !late[1] |-> !prop_neg_n && gen_ovf_n; endproperty
    a_pass: assert property (p_pass)
        else $error("lookahead pass-through levels wrong");
    property p_no_ovf; live && !arith && late[1] |-> gen_ovf_n; endproperty
    a_no_ovf: assert property (p_no_ovf)
        else $error("overflow flagged on a logic code");
    property p_drain; zero_line_out == 1'b0; endproperty
    a_drain: assert property (p_drain)
        else $error("zero line driven high");
    property p_idle; idle_cnt == 3'h7 |-> $stable(result_out_n); endproperty
    a_idle: assert property (p_idle)
        else $error("output register moved with strobe high");
    sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
    property p_rd_answer; s_rd_taken |=> s_axi_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read answer late");
    property p_rd_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_rd_refuse: assert property (p_rd_refuse)
        else $error("read accepted while answer pending");
endmodule : ars_slice_chk

// File: tb/ars_far_side.sv
// ars_far_side: board around one slice: zero line pull-up and result bus.
// Assumes this slice is the only one on both lines.
`timescale 1ns/1ps

module ars_far_side (
    input wire logic [3:0] result_out_n,
    input wire logic result_oe_n,
    input wire logic zero_line_out,
    input wire logic zero_line_oe_n,
    output logic [3:0] res_bus,
    output logic zero_line_in
);
    logic [3:0] last_bus = 4'h0;
    // a released bus shows the inverse of its last value, so stale data cannot pass
    always @(result_out_n or result_oe_n) begin
        if (!result_oe_n) last_bus = result_out_n;
    end
    assign res_bus = result_oe_n ? ~last_bus : result_out_n;
    assign zero_line_in = zero_line_oe_n ? 1'b1 : zero_line_out;
endmodule : ars_far_side

// File: tb/tb_top.sv
// tb_top: runs microcycles and register accesses on one slice.
// Assumes a single top slice or bottom slice, far side modelled by ars_far_side.
`timescale 1ns/1ps
`include "ars_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module tb_top;
    typedef struct packed {logic [2:0] w; logic [2:0] f; logic [3:0] d; logic t;
        logic [3:0] e;} ars_row_t;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] data_in_n = 4'hf;
    logic [2:0] word_sel = 3'h0, func_sel = 3'h0;
    logic top_slice_select = 1'b0, slice_clock = 1'b1;
    logic run_strobe_n = 1'b1, out_drive_en_n = 1'b1;
    logic [3:0] result_out_n, res_bus;
    logic result_oe_n, ripple_link_n, prop_neg_n, gen_ovf_n;
    logic zero_line_in, zero_line_out, zero_line_oe_n;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rp;
    logic [3:0] mem [8];
    logic [3:0] out_q = 4'h0;
    logic hold = 1'b0;
    int n_errors = 0, cmp_count = 0, cycles = 0;
    // word, code, data, top, result: all eight codes, carry in both levels
    ars_row_t rows [14] = '{'{3'h3, 3'h5, 4'h9, 1'b1, 4'h9}, '{3'h5, 3'h5, 4'h6, 1'b0, 4'h6},
        '{3'h3, 3'h0, 4'h7, 1'b1, 4'h1}, '{3'h3, 3'h1, 4'h3, 1'b1, 4'h4},
        '{3'h3, 3'h1, 4'h4, 1'b1, 4'h8}, '{3'h3, 3'h2, 4'hc, 1'b1, 4'h8},
        '{3'h3, 3'h3, 4'h3, 1'b0, 4'hb}, '{3'h3, 3'h4, 4'hb, 1'b0, 4'h0},
        '{3'h3, 3'h1, 4'hf, 1'b1, 4'hf}, '{3'h5, 3'h7, 4'h1, 1'b1, 4'h6},
        '{3'h5, 3'h6, 4'hf, 1'b1, 4'h0}, '{3'h5, 3'h0, 4'hf, 1'b0, 4'h0},
        '{3'h5, 3'h1, 4'hf, 1'b0, 4'hf}, '{3'h5, 3'h1, 4'h1, 1'b0, 4'h0}};

    ars_slice dut (.mclk, .rstn, .data_in_n, .word_sel, .func_sel, .top_slice_select,
        .slice_clock, .run_strobe_n, .out_drive_en_n, .result_out_n, .result_oe_n,
        .ripple_link_n, .prop_neg_n, .gen_ovf_n, .zero_line_in, .zero_line_out,
        .zero_line_oe_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    ars_far_side far (.result_out_n, .result_oe_n, .zero_line_out, .zero_line_oe_n,
        .res_bus, .zero_line_in);

    // ------------------------------------------------------------
    // bus and microcycle tasks
    // ------------------------------------------------------------
    always #5 mclk = ~mclk;

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
    endtask : step

    // each channel drops its valid on its own handshake; bready rises with both valids
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    // flags are checked in the low phase, while the latch still holds the operand
    task automatic mc(input ars_row_t r, input logic s);
        logic [3:0] a;
        logic [4:0] sum;
        logic [4:0] gs;
        logic [31:0] v;
        logic [1:0] q;
        a = mem[r.w];
        sum = {1'b0, a} + {1'b0, r.d} + {4'h0, ~r.f[0]};
        gs = {1'b0, a} + {1'b0, r.d};
        word_sel <= r.w;
        func_sel <= r.f;
        data_in_n <= ~r.d;
        top_slice_select <= r.t;
        run_strobe_n <= s;
        step(6);
        slice_clock <= 1'b0;
        step(6);
        `CHK(ripple_link_n, (r.f[2:1] == 2'b00) ? ~sum[4] : r.f[0])
        `CHK(zero_line_in, r.e == 4'h0)
        if (r.t) begin
            `CHK(prop_neg_n, ~r.e[3])
            `CHK(gen_ovf_n, ~(r.f[2:1] == 2'b00 && a[3] == r.d[3] && r.e[3] != a[3]))
        end else if (r.f[2:1] == 2'b00) begin
            `CHK(prop_neg_n, ~(&(a | r.d)))
            `CHK(gen_ovf_n, ~gs[4])
        end else begin
            `CHK({prop_neg_n, gen_ovf_n}, 2'b01)
        end
        slice_clock <= 1'b1;
        step(6);
        if (!s && !hold) begin
            mem[r.w] = r.e;
            out_q = r.e;
        end
        `CHK(res_bus, ~out_q)
        rd({3'h1, r.w, 2'h0}, v, q);
        `CHK(v[3:0], mem[r.w])
    endtask : mc

    task automatic results;
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            results();
        end
    end

    initial begin
        step(11);
        `CHK({ripple_link_n, prop_neg_n, gen_ovf_n, zero_line_oe_n, result_oe_n}, 5'h1f)
        step(1);
        rstn <= 1'b1;
        out_drive_en_n <= 1'b0;
        step(4);
        foreach (rows[i]) mc(rows[i], 1'b0);
        mc('{3'h3, 3'h5, 4'h5, 1'b1, 4'h5}, 1'b1);
        wr(8'h00, 32'h1, rp);
        hold = 1'b1;
        mc('{3'h5, 3'h5, 4'ha, 1'b0, 4'ha}, 1'b0);
        rd(8'h00, rdat, rp);
        `CHK(rdat[0], 1'b1)
        wr(8'h00, 32'h0, rp);
        hold = 1'b0;
        mc('{3'h5, 3'h5, 4'ha, 1'b0, 4'ha}, 1'b0);
        rd(8'h10, rdat, rp);
        `CHK({rp, rdat}, {`ARS_RESP_SLVERR, 32'h0})
        wr(8'h14, 32'h0, rp);
        `CHK(rp, `ARS_RESP_SLVERR)
        wr(8'h04, 32'hf, rp);
        `CHK(rp, `ARS_RESP_OKAY)
        rd(8'h04, rdat, rp);
        `CHK(rdat[3:0], out_q)
        out_drive_en_n <= 1'b1;
        step(5);
        `CHK(result_oe_n, 1'b1)
        results();
    end
endmodule : tb_top

bind ars_slice ars_slice_chk u_chk (.mclk, .rstn, .func_sel, .top_slice_select,
    .run_strobe_n, .out_drive_en_n, .result_out_n, .result_oe_n, .ripple_link_n,
    .prop_neg_n, .gen_ovf_n, .zero_line_out, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid);
